// *** verif/masdio_chk.sv ***
// assertions for the strap address and digital io mode block
// assumes it is bound into masdio_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module masdio_chk #(
  parameter int NUM_PINS = 15
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pads and status
  input wire logic [NUM_PINS-1:0] digital_io_pin_out,
  input wire logic [NUM_PINS-1:0] digital_io_pin_oe,
  input wire logic [NUM_PINS-1:0] digital_io_pin_pd,
  input wire logic [7:0] module_addr,
  input wire logic [31:0] active_settings
);
  import masdio_pkg::*;
  // ----
  // boot window
  // ----
  // strap and settings may only move in the few cycles after a boot
  logic [2:0] boot_cnt_ff;
  logic [2:0] nxt_boot_cnt;
  wire sw_boot = psel && penable && pready && pwrite && paddr == OFS_SW_RESET && pwdata[0];
  wire rd_done = pready && !pwrite;
  assign nxt_boot_cnt = sw_boot ? 3'h7 : (boot_cnt_ff != 3'h0) ? boot_cnt_ff - 3'h1 : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) boot_cnt_ff <= 3'h7;
    else boot_cnt_ff <= nxt_boot_cnt;
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  apb_answer_a: assert property (s_access |=> s_answer)
    else $error("apb answer not a one cycle pulse after access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  slots_ro_a: assert property (rd_done && paddr == OFS_SLOTS |-> prdata == 32'h0000_010c)
    else $error("slot counts read wrong");
  addr_read_a: assert property (rd_done && paddr == OFS_ADDR |-> prdata == {24'h0, module_addr})
    else $error("address register differs from module_addr");
  addr_even_a: assert property (!module_addr[0] && module_addr inside {[8'h04:8'h22]})
    else $error("module_addr not base plus doubled strap");
  addr_boot_a: assert property (boot_cnt_ff == 3'h0 |-> $stable(module_addr))
    else $error("module_addr moved outside boot");
  settings_boot_a: assert property (boot_cnt_ff == 3'h0 |-> $stable(active_settings))
    else $error("active settings moved outside boot");
  drive_oe_a: assert property ((digital_io_pin_out & ~digital_io_pin_oe) == '0)
    else $error("pin driven high without output enable");
  pull_oe_a: assert property ((digital_io_pin_pd & digital_io_pin_oe) == '0)
    else $error("pull-down together with output enable");
endmodule // masdio_chk
bind masdio_top masdio_chk #(.NUM_PINS(NUM_PINS)) i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .digital_io_pin_out,
  .digital_io_pin_oe, .digital_io_pin_pd, .module_addr, .active_settings);
`default_nettype wire

// *** verif/masdio_top_tb.sv ***
// self-checking bench for the strap address and digital io mode block
// assumes masdio_top with the checker bound in; apb master lives here
`timescale 1ns/10ps
`default_nettype none
module masdio_top_tb;
  import masdio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, active_settings, rd;
  logic [3:0] strap_n;
  logic [14:0] digital_io_pin_in, digital_io_pin_out, digital_io_pin_oe, digital_io_pin_pd;
  logic [7:0] module_addr;
  int mismatches, checked;
  always #12.5 pclk = ~pclk;
  masdio_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .strap_n, .digital_io_pin_in, .digital_io_pin_out,
    .digital_io_pin_oe, .digital_io_pin_pd, .module_addr, .active_settings);
  // ----
  // helpers
  // ----
  task automatic test_done();
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // pready and prdata are taken at the rising edge, before that edge's own updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("unexpected pready expected 1 seen %b", pready);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic setm(input int p, input int c);
    apb(1'b1, OFS_MODE_SEL, 32'(p));
    apb(1'b1, OFS_MODE_DATA, 32'(c));
  endtask
  task automatic boot(input logic [3:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    strap_n <= ~s;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_strap();
    logic [3:0] tbl [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hf};
    foreach (tbl[i]) begin
      boot(tbl[i]);
      chk("module_addr", 32'h4 + {tbl[i], 1'b0}, 32'(module_addr));
      rdchk("addr reg", OFS_ADDR, 32'h4 + {tbl[i], 1'b0});
    end
    @(posedge pclk);
    strap_n <= 4'he;
    repeat (8) @(posedge pclk);
    chk("held addr", 32'h22, 32'(module_addr));
    apb(1'b1, OFS_SW_RESET, 32'h1);
    repeat (8) @(posedge pclk);
    chk("reboot addr", 32'h6, 32'(module_addr));
  endtask
  // pin 5 takes servo out but not servo in; codes 6 and 7 do not exist
  task automatic t_modes();
    int m;
    boot(4'h0);
    m = 0;
    for (int c = 0; c < 8; c++) begin
      setm(5, c);
      if (c != 2 && c < 6) m = c;
      rdchk("mode", OFS_MODE_DATA, 32'(m));
      rdchk("error", OFS_ERROR, (c == 2 || c > 5) ? 32'h1 : 32'h0);
      apb(1'b1, OFS_ERROR, 32'h0);
      chk("oe", 32'(m == 1 || m == 3), 32'(digital_io_pin_oe[5]));
      chk("pd", 32'(m == 5), 32'(digital_io_pin_pd[5]));
    end
    setm(2, 2);
    setm(2, 3);
    rdchk("servo in", OFS_MODE_DATA, 32'h2);
    rdchk("servo err", OFS_ERROR, 32'h1);
    apb(1'b1, OFS_ERROR, 32'h0);
    setm(14, 1);
    rdchk("last pin", OFS_MODE_DATA, 32'h1);
    apb(1'b1, OFS_MODE_SEL, 32'd15);
    rdchk("bad pin", OFS_ERROR, 32'h2);
  endtask
  task automatic t_pins();
    boot(4'h0);
    setm(3, 1);
    setm(6, 4);
    apb(1'b1, OFS_PIN_OUT, 32'h0048);
    rdchk("out err", OFS_ERROR, 32'h3);
    chk("pin out", 32'h0008, 32'(digital_io_pin_out));
    @(posedge pclk);
    digital_io_pin_in <= 15'h7fff;
    repeat (4) @(posedge pclk);
    rdchk("pin in", OFS_PIN_IN, 32'h7fb7);
  endtask
  task automatic t_save();
    boot(4'h0);
    apb(1'b1, OFS_SAVE_DATA, 32'h9a3c_5e71);
    apb(1'b1, OFS_SAVE_CTRL, 32'h1);
    rdchk("nv word", OFS_NV_DATA, 32'h9a3c_5e71);
    chk("not yet", 32'h0, active_settings);
    apb(1'b1, OFS_SW_RESET, 32'h1);
    repeat (8) @(posedge pclk);
    chk("applied", 32'h9a3c_5e71, active_settings);
    rdchk("slots", OFS_SLOTS, 32'h0000_010c);
    // only an unmapped write records the refusal in the error register
    apb(1'b1, 12'h030, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    rdchk("map err", OFS_ERROR, 32'h1);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap_n = 4'hf;
    digital_io_pin_in = 15'h0000;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_strap();
    t_modes();
    t_pins();
    t_save();
    test_done();
  end
endmodule // masdio_top_tb
`default_nettype wire

// *** verilog/masdio_pin_cell.sv ***
// one digital io pin: mode decode, pad enables and input synchroniser
// assumes pin_in comes straight from a pad, outside the pclk domain
`timescale 1ns/10ps
`default_nettype none
module masdio_pin_cell (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic [masdio_pkg::MODE_W-1:0] mode,
  input wire logic drive_val,
  // pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pd,
  // user side
  output logic pin_val
);
  import masdio_pkg::*;
  logic sync1_ff;
  logic sync2_ff;
  logic oe_ff;
  logic out_ff;
  logic pd_ff;
  logic val_ff;
  wire logic drives = (mode == MODE_OUTPUT) || (mode == MODE_SERVO_OUT);
  wire logic reads = (mode == MODE_INPUT) || (mode == MODE_IN_PULLDN) ||
                     (mode == MODE_SERVO_IN);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      oe_ff <= 1'b0;
      out_ff <= 1'b0;
      pd_ff <= 1'b0;
      val_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      oe_ff <= drives;
      out_ff <= drives & drive_val;
      pd_ff <= (mode == MODE_IN_PULLDN);
      // hi-z and output modes read nothing back from the pad
      val_ff <= reads & sync2_ff;
    end
  end
  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign pin_pd = pd_ff;
  assign pin_val = val_ff;
endmodule // masdio_pin_cell
`default_nettype wire

// *** verilog/masdio_pkg.sv ***
// package for the module address strap and digital io mode block
// assumes a single pclk domain with apb register access
package masdio_pkg;
  // -----------------------------------------------------------------
  // sizes
  // -----------------------------------------------------------------
  localparam int NUM_PINS = 15;
  localparam int STRAP_W = 4;
  localparam int ADDR_W = 8;
  localparam int MODE_W = 3;
  localparam int FLASH_SLOTS = 12;
  localparam int RAM_SLOTS = 1;
  // -----------------------------------------------------------------
  // address and reset values
  // -----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BASE_ADDR = 8'h04;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_INVALID_OPTION = 8'h01;
  localparam logic [7:0] ERR_INVALID_ENTITY = 8'h02;
  localparam logic [7:0] ERR_MODE = 8'h03;
  // -----------------------------------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [11:0] OFS_ADDR = 12'h000;
  localparam logic [11:0] OFS_MODE_SEL = 12'h004;
  localparam logic [11:0] OFS_MODE_DATA = 12'h008;
  localparam logic [11:0] OFS_ERROR = 12'h00c;
  localparam logic [11:0] OFS_SAVE_DATA = 12'h010;
  localparam logic [11:0] OFS_SAVE_CTRL = 12'h014;
  localparam logic [11:0] OFS_NV_DATA = 12'h018;
  localparam logic [11:0] OFS_SLOTS = 12'h01c;
  localparam logic [11:0] OFS_PIN_OUT = 12'h020;
  localparam logic [11:0] OFS_PIN_IN = 12'h024;
  localparam logic [11:0] OFS_SW_RESET = 12'h028;
  // saved field positions in the save data word
  localparam int SV_SWOFS_LSB = 0;
  localparam int SV_I2C_LSB = 8;
  localparam int SV_ROUTER_LSB = 12;
  localparam int SV_BOOT_LSB = 20;
  localparam int SV_HB_LSB = 24;
  localparam logic [31:0] SAVE_RST = 32'h0000_0000;
  // -----------------------------------------------------------------
  // pin mode codes
  // -----------------------------------------------------------------
  typedef enum logic [MODE_W-1:0] {
    MODE_INPUT = 3'h0,
    MODE_OUTPUT = 3'h1,
    MODE_SERVO_IN = 3'h2,
    MODE_SERVO_OUT = 3'h3,
    MODE_HIZ = 3'h4,
    MODE_IN_PULLDN = 3'h5
  } masdio_mode_t;
  // servo input on pins 0..3, servo output on pins 4..7
  localparam logic [NUM_PINS-1:0] SERVO_IN_PINS = 15'h000f;
  localparam logic [NUM_PINS-1:0] SERVO_OUT_PINS = 15'h00f0;
endpackage

// *** verilog/masdio_top.sv ***
// module address strap capture, saved settings and digital io mode registers
// assumes an apb master on pclk; strap and pin pads are asynchronous inputs
//
// Contract
// - strap pins are captured only at boot (reset release or software reset) and held after.
// - the four captured strap bits form a number with pin 0 as lsb and pin 3 as msb.
// - the strap number is doubled to form the address offset.
// - the module address is the doubled offset plus a base of four.
// - software offset, i2c rate, router, boot slot and heartbeat are saved and used after reboot; kept over a software reset only, presetn clears them.
// - there are twelve flash program slots and one ram slot.
// - there are fifteen digital io pins, each with its own mode.
// - each pin can be input or output and its mode reads back.
// - mode codes 0..4 are input, output, servo in, servo out and hi-z.
// - an unsupported option is refused with an error code naming the reason.
// - mode code 5 is input with pull-down.
// - in hi-z neither drive nor read acts on the pin.
`timescale 1ns/10ps
`default_nettype none
module masdio_top #(
  parameter int NUM_PINS = masdio_pkg::NUM_PINS
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins, low when grounded
  input wire logic [masdio_pkg::STRAP_W-1:0] strap_n,
  // digital io pads
  input wire logic [NUM_PINS-1:0] digital_io_pin_in,
  output logic [NUM_PINS-1:0] digital_io_pin_out,
  output logic [NUM_PINS-1:0] digital_io_pin_oe,
  output logic [NUM_PINS-1:0] digital_io_pin_pd,
  // status
  output logic [masdio_pkg::ADDR_W-1:0] module_addr,
  output logic [31:0] active_settings
);
  import masdio_pkg::*;

  // ---------------------------------------------------------------
  // strap synchroniser and boot capture
  // ---------------------------------------------------------------
  logic [STRAP_W-1:0] strap_s1_ff;
  logic [STRAP_W-1:0] strap_s2_ff;
  logic boot_pend_ff;
  logic nxt_boot_pend;
  logic [1:0] boot_wait_ff;
  logic [STRAP_W-1:0] strap_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [31:0] active_ff;
  logic [31:0] save_data_ff;
  logic [31:0] nv_ff;
  logic [MODE_W-1:0] mode_ff [NUM_PINS];
  logic [NUM_PINS-1:0] drive_ff;
  logic [3:0] sel_ff;
  logic [7:0] err_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [NUM_PINS-1:0] pin_val;

  // a grounded pin reads low, so the bit value is the inverted level
  wire logic [STRAP_W-1:0] strap_bits = ~strap_s2_ff;
  wire logic [ADDR_W-1:0] strap_ofs = {{(ADDR_W-STRAP_W-1){1'b0}}, strap_ff, 1'b0};
  wire logic [ADDR_W-1:0] final_addr = BASE_ADDR + strap_ofs;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic acc = psel & penable & ~pready_ff;
  wire logic wr = acc & pwrite;
  wire logic rd = acc & ~pwrite;
  wire logic hit_addr = (paddr == OFS_ADDR);
  wire logic hit_sel = (paddr == OFS_MODE_SEL);
  wire logic hit_mode = (paddr == OFS_MODE_DATA);
  wire logic hit_err = (paddr == OFS_ERROR);
  wire logic hit_sdat = (paddr == OFS_SAVE_DATA);
  wire logic hit_sctl = (paddr == OFS_SAVE_CTRL);
  wire logic hit_nv = (paddr == OFS_NV_DATA);
  wire logic hit_slot = (paddr == OFS_SLOTS);
  wire logic hit_pout = (paddr == OFS_PIN_OUT);
  wire logic hit_pin = (paddr == OFS_PIN_IN);
  wire logic hit_rst = (paddr == OFS_SW_RESET);
  wire logic hit_any = hit_addr | hit_sel | hit_mode | hit_err | hit_sdat | hit_sctl |
                       hit_nv | hit_slot | hit_pout | hit_pin | hit_rst;
  wire logic sel_ok = (sel_ff < 4'(NUM_PINS));
  wire logic [MODE_W-1:0] new_mode = pwdata[MODE_W-1:0];

  // support check for a mode code on a given pin
  function automatic logic mode_ok(input logic [31:0] code, input logic [3:0] pin);
    logic ok;
    ok = 1'b0;
    unique case (code)
      32'(MODE_INPUT), 32'(MODE_OUTPUT), 32'(MODE_HIZ), 32'(MODE_IN_PULLDN): ok = 1'b1;
      32'(MODE_SERVO_IN): ok = SERVO_IN_PINS[pin];
      32'(MODE_SERVO_OUT): ok = SERVO_OUT_PINS[pin];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  wire logic mode_wr = wr & hit_mode;
  wire logic mode_good = sel_ok & mode_ok(pwdata, sel_ff);
  wire logic bad_sel_wr = wr & hit_sel & (pwdata[31:4] != 28'h0 || pwdata[3:0] >= 4'(NUM_PINS));
  wire logic sw_reset = wr & hit_rst & pwdata[0];

  // error code of this access, held until the next refusal or a clear
  wire logic [7:0] nxt_err =
    (mode_wr & ~sel_ok) ? ERR_INVALID_ENTITY :
    (mode_wr & ~mode_good) ? ERR_INVALID_OPTION :
    bad_sel_wr ? ERR_INVALID_ENTITY :
    (wr & hit_pout & (|(pwdata[NUM_PINS-1:0] & ~drive_mask()))) ? ERR_MODE :
    (wr & ~hit_any) ? ERR_INVALID_OPTION :
    (wr & hit_err) ? ERR_NONE : err_ff;

  function automatic logic [NUM_PINS-1:0] drive_mask();
    logic [NUM_PINS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      m[i] = (mode_ff[i] == MODE_OUTPUT);
    end
    return m;
  endfunction

  wire logic [MODE_W-1:0] cur_mode = sel_ok ? mode_ff[sel_ff] : MODE_RST;
  wire logic [31:0] rd_mux =
    hit_addr ? {24'h0, addr_ff} :
    hit_sel ? {28'h0, sel_ff} :
    hit_mode ? {29'h0, cur_mode} :
    hit_err ? {24'h0, err_ff} :
    hit_sdat ? save_data_ff :
    hit_nv ? nv_ff :
    hit_slot ? {16'h0, 8'(RAM_SLOTS), 8'(FLASH_SLOTS)} :
    hit_pout ? {17'h0, drive_ff} :
    hit_pin ? {17'h0, pin_val} :
    32'h0;

  // ---------------------------------------------------------------
  // boot sequencing
  // ---------------------------------------------------------------
  // wait two cycles after release so the synchroniser holds real pad levels
  assign nxt_boot_pend = sw_reset ? 1'b1 : (boot_wait_ff == 2'h0 ? 1'b0 : boot_pend_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_ff <= '0;
      strap_s2_ff <= '0;
      boot_pend_ff <= 1'b1;
      boot_wait_ff <= 2'h2;
    end else begin
      strap_s1_ff <= strap_n;
      strap_s2_ff <= strap_s1_ff;
      boot_pend_ff <= nxt_boot_pend;
      boot_wait_ff <= sw_reset ? 2'h2 : (boot_wait_ff != 2'h0 ? boot_wait_ff - 2'h1 : 2'h0);
    end
  end

  wire logic boot_now = boot_pend_ff & (boot_wait_ff == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_ff <= '0;
      addr_ff <= BASE_ADDR;
      active_ff <= SAVE_RST;
    end else begin
      if (boot_now) begin
        strap_ff <= strap_bits;
        active_ff <= nv_ff;
      end
      addr_ff <= final_addr;
    end
  end

  // ---------------------------------------------------------------
  // saved settings: staged word, committed on save, used after boot
  // ---------------------------------------------------------------
  // nv_ff survives the software reset but not presetn, standing in for flash
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_data_ff <= SAVE_RST;
      nv_ff <= SAVE_RST;
    end else begin
      if (wr & hit_sdat) begin
        save_data_ff <= pwdata;
      end
      if (wr & hit_sctl & pwdata[0]) begin
        nv_ff <= save_data_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin modes and drive levels
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        mode_ff[i] <= MODE_RST;
      end
      drive_ff <= '0;
      sel_ff <= 4'h0;
      err_ff <= ERR_NONE;
    end else begin
      if (sw_reset) begin
        for (int i = 0; i < NUM_PINS; i++) begin
          mode_ff[i] <= MODE_RST;
        end
        drive_ff <= '0;
      end else begin
        if (mode_wr & mode_good) begin
          mode_ff[sel_ff] <= new_mode;
        end
        if (wr & hit_pout) begin
          // only pins in output mode take a drive level
          drive_ff <= (drive_ff & ~drive_mask()) | (pwdata[NUM_PINS-1:0] & drive_mask());
        end
      end
      if (wr & hit_sel & ~bad_sel_wr) begin
        sel_ff <= pwdata[3:0];
      end
      err_ff <= nxt_err;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: one wait state, ready and data registered
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & ~hit_any;
      prdata_ff <= rd ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // pin cells
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    masdio_pin_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .mode(mode_ff[g]),
      .drive_val(drive_ff[g]),
      .pin_in(digital_io_pin_in[g]),
      .pin_out(digital_io_pin_out[g]),
      .pin_oe(digital_io_pin_oe[g]),
      .pin_pd(digital_io_pin_pd[g]),
      .pin_val(pin_val[g])
    );
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign module_addr = addr_ff;
  assign active_settings = active_ff;
endmodule // masdio_top
`default_nettype wire
